// [i2cirq_consts.svh]
`ifndef I2CIRQ_CONSTS_SVH
`define I2CIRQ_CONSTS_SVH

`define I2CIRQ_DATA_W        32
`define I2CIRQ_NEVT          4
`define I2CIRQ_RSV_W         28
`define I2CIRQ_NSETUP        6

`define I2CIRQ_OFF_RAW       8'h00
`define I2CIRQ_OFF_MASK      8'h04
`define I2CIRQ_OFF_CLR       8'h08
`define I2CIRQ_OFF_SETUP1    8'h0C
`define I2CIRQ_OFF_SETUP2    8'h10
`define I2CIRQ_OFF_SETUP3    8'h14
`define I2CIRQ_OFF_PEER      8'h18
`define I2CIRQ_OFF_PAYLOAD   8'h1C
`define I2CIRQ_OFF_LOCATION  8'h20
`define I2CIRQ_OFF_CMD       8'h24

`define I2CIRQ_SETUP_BASE_IX 4'h3
`define I2CIRQ_CMD_IX        4'h9

`define I2CIRQ_BIT_ACK       0
`define I2CIRQ_BIT_STOP      1
`define I2CIRQ_BIT_NOACK     2
`define I2CIRQ_BIT_ARB       3

`define I2CIRQ_RAW_RST       4'h0
`define I2CIRQ_MASK_RST      4'hF
`define I2CIRQ_REG_RST       32'h0000_0000
`define I2CIRQ_SYNC_RST      1'b0
`define I2CIRQ_SCL_IDLE      1'b1

`endif

// [i2cirq_pkg.sv]
package i2cirq_pkg;
  // event levels from the serial engine, in scl domain
  typedef struct packed {
    logic arb_lost;
    logic no_ack;
    logic stop_done;
    logic ack_done;
  } i2cirq_evt_t;

  typedef struct packed {
    logic [31:0] setup_primary;
    logic [31:0] setup_secondary;
    logic [31:0] setup_tertiary;
    logic [31:0] peer_bus_id;
    logic [31:0] transfer_payload;
    logic [31:0] transfer_location;
  } i2cirq_setup_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } i2cirq_cmd_t;
endpackage

// [i2cirq_sync.sv]
`include "i2cirq_consts.svh"
module i2cirq_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (sys_rst_in) begin
      meta_nxt = {WIDTH{`I2CIRQ_SYNC_RST}};
      sync_nxt = {WIDTH{`I2CIRQ_SYNC_RST}};
    end else if (clk_en_in) begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = sync_r;
endmodule

// [i2cirq_flags.sv]
`include "i2cirq_consts.svh"
module i2cirq_flags #(
  parameter int N = `I2CIRQ_NEVT
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clk_en_in,
  input  wire logic [N-1:0] set_in,
  input  wire logic [N-1:0] clr_in,
  output logic      [N-1:0] flags_out,
  output logic      [N-1:0] flags_nxt_out
);
  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  always_comb begin
    flags_nxt = flags_r;
    if (sys_rst_in) begin
      flags_nxt = N'(`I2CIRQ_RAW_RST);
    end else if (clk_en_in) begin
      // set applied after clear so a coincident event survives
      flags_nxt = (flags_r & ~clr_in) | set_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    flags_r <= flags_nxt;
  end

  assign flags_out     = flags_r;
  assign flags_nxt_out = flags_nxt;
endmodule

// [i2cirq_top.sv]
// Behaviour
// - raw event flags readable at offset zero
// - bit 3 set on arbitration loss
// - bit 2 set on missing acknowledge
// - bit 0 set on acknowledge complete
// - per-flag mask bit, one blocks interrupt
// - all mask bits set after reset
// - writing one to clear bit clears flag
// - interrupt high on any unmasked flag
// - ten word registers, read-only and write-only honoured
`include "i2cirq_consts.svh"
module i2cirq_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                      mclk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      clk_en_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [ADDR_W-1:0]         paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  input  wire logic                      scl_in,
  input  wire i2cirq_pkg::i2cirq_evt_t   evt_in,
  output logic                           irq_out,
  output i2cirq_pkg::i2cirq_setup_t      setup_out,
  output i2cirq_pkg::i2cirq_cmd_t        cmd_out
);
  import i2cirq_pkg::*;

  localparam int NE = `I2CIRQ_NEVT;
  localparam int NS = `I2CIRQ_NSETUP;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    reg_hit = (a == ADDR_W'(off));
  endfunction

  function automatic logic [3:0] word_ix(input logic [ADDR_W-1:0] a);
    word_ix = a[5:2];
  endfunction

  // ---------------- link sampling ----------------
  logic [NE:0]  link_s;
  logic         scl_s;
  logic [NE-1:0] evt_s;
  logic         scl_d_r;
  logic         scl_d_nxt;
  logic [NE-1:0] evt_prev_r;
  logic [NE-1:0] evt_prev_nxt;
  logic         scl_rise;
  logic [NE-1:0] evt_set;

  i2cirq_sync #(
    .WIDTH (NE + 1)
  ) u_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({~scl_in, evt_in}),
    .sync_out   (link_s)
  );

  // scl is synced inverted so a cleared stage reads as idle high: no false rise after reset
  assign scl_s    = ~link_s[NE];
  assign evt_s    = link_s[NE-1:0];
  assign scl_rise = scl_s & ~scl_d_r;
  // engine outputs change on scl, so they are judged on its rising edge
  assign evt_set  = scl_rise ? (evt_s & ~evt_prev_r) : {NE{1'b0}};

  always_comb begin
    scl_d_nxt    = scl_d_r;
    evt_prev_nxt = evt_prev_r;
    if (sys_rst_in) begin
      scl_d_nxt    = `I2CIRQ_SCL_IDLE;
      evt_prev_nxt = NE'(`I2CIRQ_RAW_RST);
    end else if (clk_en_in) begin
      scl_d_nxt = scl_s;
      if (scl_rise) begin
        evt_prev_nxt = evt_s;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    scl_d_r    <= scl_d_nxt;
    evt_prev_r <= evt_prev_nxt;
  end

  // ---------------- APB decode ----------------
  logic mapped;
  logic acc;
  logic wr_en;
  logic rd_setup;
  logic [3:0] ix;

  assign ix       = word_ix(paddr_in);
  assign mapped   = (paddr_in[1:0] == 2'h0) &&
                    (paddr_in <= ADDR_W'(`I2CIRQ_OFF_CMD));
  assign acc      = psel_in & penable_in;
  assign wr_en    = acc & pwrite_in & mapped & clk_en_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
  // zero wait states: read data is captured in the setup cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~mapped;

  // ---------------- interrupt flags ----------------
  logic [NE-1:0] raw;
  logic [NE-1:0] raw_nxt;
  logic [NE-1:0] clr_req;

  assign clr_req = (wr_en && reg_hit(paddr_in, `I2CIRQ_OFF_CLR)) ?
                   pwdata_in[NE-1:0] : {NE{1'b0}};

  i2cirq_flags #(
    .N (NE)
  ) u_flags (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .set_in        (evt_set),
    .clr_in        (clr_req),
    .flags_out     (raw),
    .flags_nxt_out (raw_nxt)
  );

  // ---------------- register file ----------------
  logic [NE-1:0] mask_r;
  logic [NE-1:0] mask_nxt;
  logic [31:0]   setup_r [NS];
  logic [31:0]   setup_nxt [NS];
  logic [31:0]   cmd_data_r;
  logic [31:0]   cmd_data_nxt;
  logic          cmd_valid_r;
  logic          cmd_valid_nxt;
  logic [31:0]   prdata_r;
  logic [31:0]   prdata_nxt;
  logic          irq_r;
  logic          irq_nxt;
  logic [3:0]    sidx;

  assign sidx = ix - `I2CIRQ_SETUP_BASE_IX;

  always_comb begin
    mask_nxt      = mask_r;
    setup_nxt     = setup_r;
    cmd_data_nxt  = cmd_data_r;
    cmd_valid_nxt = cmd_valid_r;
    prdata_nxt    = prdata_r;
    if (sys_rst_in) begin
      mask_nxt      = `I2CIRQ_MASK_RST;
      for (int i = 0; i < NS; i++) begin
        setup_nxt[i] = `I2CIRQ_REG_RST;
      end
      cmd_data_nxt  = `I2CIRQ_REG_RST;
      cmd_valid_nxt = 1'b0;
      prdata_nxt    = `I2CIRQ_REG_RST;
    end else if (clk_en_in) begin
      cmd_valid_nxt = 1'b0;
      if (wr_en) begin
        if (reg_hit(paddr_in, `I2CIRQ_OFF_MASK)) begin
          mask_nxt = pwdata_in[NE-1:0];
        end
        if (ix >= `I2CIRQ_SETUP_BASE_IX && ix < `I2CIRQ_CMD_IX) begin
          setup_nxt[sidx[2:0]] = pwdata_in;
        end
        if (ix == `I2CIRQ_CMD_IX) begin
          cmd_data_nxt  = pwdata_in;
          cmd_valid_nxt = 1'b1;
        end
      end
      if (rd_setup) begin
        prdata_nxt = `I2CIRQ_REG_RST;
        if (reg_hit(paddr_in, `I2CIRQ_OFF_RAW)) begin
          prdata_nxt = {`I2CIRQ_RSV_W'(0), raw};
        end else if (reg_hit(paddr_in, `I2CIRQ_OFF_MASK)) begin
          prdata_nxt = {`I2CIRQ_RSV_W'(0), mask_r};
        end else if (mapped && ix >= `I2CIRQ_SETUP_BASE_IX &&
                     ix < `I2CIRQ_CMD_IX) begin
          prdata_nxt = setup_r[sidx[2:0]];
        end
      end
    end
  end

  always_comb begin
    irq_nxt = irq_r;
    if (sys_rst_in) begin
      irq_nxt = 1'b0;
    end else if (clk_en_in) begin
      // built from next values so the pin tracks the flags without lag
      irq_nxt = |(raw_nxt & ~mask_nxt);
    end
  end

  always_ff @(posedge mclk_in) begin
    mask_r      <= mask_nxt;
    setup_r     <= setup_nxt;
    cmd_data_r  <= cmd_data_nxt;
    cmd_valid_r <= cmd_valid_nxt;
    prdata_r    <= prdata_nxt;
    irq_r       <= irq_nxt;
  end

  assign prdata_out                  = prdata_r;
  assign irq_out                     = irq_r;
  assign setup_out.setup_primary     = setup_r[0];
  assign setup_out.setup_secondary   = setup_r[1];
  assign setup_out.setup_tertiary    = setup_r[2];
  assign setup_out.peer_bus_id       = setup_r[3];
  assign setup_out.transfer_payload  = setup_r[4];
  assign setup_out.transfer_location = setup_r[5];
  assign cmd_out.valid               = cmd_valid_r;
  assign cmd_out.data                = cmd_data_r;

  // ---------------- assertions ----------------
  property p_raw_read;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (rd_setup && clk_en_in && reg_hit(paddr_in, `I2CIRQ_OFF_RAW)) |=>
        (prdata_out == {`I2CIRQ_RSV_W'(0), $past(raw)});
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw read mismatch");

  property p_arb_set;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (clk_en_in && evt_set[`I2CIRQ_BIT_ARB]) |=> raw[`I2CIRQ_BIT_ARB];
  endproperty
  a_arb_set: assert property (p_arb_set) else $error("arb flag not set");

  property p_noack_set;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (clk_en_in && scl_rise && evt_s[`I2CIRQ_BIT_NOACK] &&
       !evt_prev_r[`I2CIRQ_BIT_NOACK]) |=> raw[`I2CIRQ_BIT_NOACK];
  endproperty
  a_noack_set: assert property (p_noack_set) else $error("noack flag not set");

  property p_stop_set;
    @(posedge mclk_in) disable iff (sys_rst_in)
      $rose(raw[`I2CIRQ_BIT_STOP]) |-> $past(evt_set[`I2CIRQ_BIT_STOP]);
  endproperty
  a_stop_set: assert property (p_stop_set) else $error("stop flag without event");

  property p_ack_set;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (clk_en_in && evt_set[`I2CIRQ_BIT_ACK]) |=> raw[`I2CIRQ_BIT_ACK];
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("ack flag not set");

  property p_mask_wr;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (wr_en && reg_hit(paddr_in, `I2CIRQ_OFF_MASK)) |=>
        (mask_r == $past(pwdata_in[NE-1:0]));
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_mask_rst;
    @(posedge mclk_in) sys_rst_in |=> (mask_r == `I2CIRQ_MASK_RST && !irq_out);
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask reset value wrong");

  property p_clear;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (clk_en_in && |clr_req) |=>
        ((raw & $past(clr_req) & ~$past(evt_set)) == {NE{1'b0}});
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear");

  property p_irq;
    @(posedge mclk_in) disable iff (sys_rst_in)
      irq_out == |(raw & ~mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level mismatch");

  property p_unmapped;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (acc && !mapped) |-> (pslverr_out && pready_out);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not flagged");

  property p_keep;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (clk_en_in && |clr_req) |=>
        ((raw & ~$past(clr_req)) == (($past(raw) | $past(evt_set)) & ~$past(clr_req)));
  endproperty
  a_keep: assert property (p_keep) else $error("zero clear bit changed flag");

  property p_set_wins;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (clk_en_in && |(clr_req & evt_set)) |=> |(raw & $past(clr_req & evt_set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_cmd_pulse;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (wr_en && ix == `I2CIRQ_CMD_IX) |=>
        (cmd_out.valid && cmd_out.data == $past(pwdata_in));
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command not issued");

  property p_cmd_once;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (cmd_out.valid && clk_en_in) |=> !cmd_out.valid;
  endproperty
  a_cmd_once: assert property (p_cmd_once) else $error("command pulse too long");

  property p_rd_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
      !(rd_setup && clk_en_in) |=> $stable(prdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

// [i2cirq_link_model.sv]
module i2cirq_link_model (
  input  wire logic                 go_in,
  input  wire logic [3:0]           evt_req_in,
  output logic                      scl_out,
  output i2cirq_pkg::i2cirq_evt_t   evt_out,
  output logic                      busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import i2cirq_pkg::*;

  // scl has a pull-up, so it idles high between frames
  initial begin
    scl_out  = 1'b1;
    evt_out  = '0;
    busy_out = 1'b0;
  end

  // level stays stable across one rise, then low across the next so it can fire again
  always @(posedge go_in) begin
    busy_out = 1'b1;
    // offset keeps every pin change clear of the sampling clock edges
    #10 evt_out = i2cirq_evt_t'(evt_req_in);
    #160 scl_out = 1'b0;
    #160 scl_out = 1'b1;
    #160 scl_out = 1'b0;
    evt_out  = '0;
    #160 scl_out = 1'b1;
    #160 busy_out = 1'b0;
  end
endmodule

// [i2cirq_top_tb.sv]
module i2cirq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import i2cirq_pkg::*;

  logic          mclk    = 1'b0;
  logic          rst     = 1'b1;
  logic          psel    = 1'b0;
  logic          pen     = 1'b0;
  logic          pwr     = 1'b0;
  logic [11:0]   paddr   = 12'h000;
  logic [31:0]   pwdata  = 32'h0000_0000;
  logic [31:0]   prdata;
  logic [31:0]   rd;
  logic          pready;
  logic          pslverr;
  logic          err;
  logic          irq;
  logic          scl;
  logic          go      = 1'b0;
  logic          busy;
  logic [3:0]    req     = 4'h0;
  logic          cen     = 1'b1;
  i2cirq_evt_t   evt;
  i2cirq_setup_t setup;
  i2cirq_cmd_t   cmd;
  int            num_errors = 0;
  int            n_tests    = 0;

  always #20 mclk = ~mclk;

  i2cirq_top i_dut (
    .mclk_in(mclk), .sys_rst_in(rst), .clk_en_in(cen), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .scl_in(scl), .evt_in(evt), .irq_out(irq), .setup_out(setup), .cmd_out(cmd)
  );

  i2cirq_link_model i_link (
    .go_in(go), .evt_req_in(req), .scl_out(scl), .evt_out(evt), .busy_out(busy)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // idle cycle first, so strobes are never reassigned in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  // irq is registered: look once the edge's updates have landed
  task automatic ichk(input logic exp);
    @(negedge mclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic fire(input int i);
    int n;
    @(posedge mclk);
    req <= 4'(1 << i);
    go  <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) num_errors++;
    repeat (5) @(posedge mclk);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rchk(12'h004, 32'h0000_000F, "mask_rst");
    rchk(12'h000, 32'h0000_0000, "raw_rst");
    ichk(1'b0);
    wr(12'h004, 32'hFFFF_FFFF);
    rchk(12'h004, 32'h0000_000F, "mask_rsv");
    for (int k = 0; k < 6; k++) wr(12'(12'h00C + 4 * k), 32'hC0DE_0000 | k);
    for (int k = 0; k < 6; k++) rchk(12'(12'h00C + 4 * k), 32'hC0DE_0000 | k, "setup");
    for (int k = 0; k < 6; k++) chk("setup_out", setup[191-32*k -: 32], 32'hC0DE_0000 | k);
    wr(12'h000, 32'h0000_000F);
    rchk(12'h000, 32'h0000_0000, "raw_ro");
    wr(12'h024, 32'hA5A5_0001);
    @(negedge mclk);
    chk("cmd_data", cmd.data, 32'hA5A5_0001);
    chk("cmd_valid", {31'h0, cmd.valid}, 32'h0000_0001);
    @(negedge mclk);
    chk("cmd_pulse", {31'h0, cmd.valid}, 32'h0000_0000);
    rchk(12'h024, 32'h0000_0000, "cmd_rd");
    rchk(12'h008, 32'h0000_0000, "clr_rd");
    chk("map_err", {31'h0, err}, 32'h0000_0000);
    rchk(12'h028, 32'h0000_0000, "unmap_rd");
    chk("unmap_err", {31'h0, err}, 32'h0000_0001);
    wr(12'h004, 32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      fire(i);
      rchk(12'h000, 32'(1 << i), "raw_evt");
      ichk(1'b0);
      wr(12'h004, 32'(~(1 << i)) & 32'h0000_000F);
      ichk(1'b1);
      wr(12'h008, 32'(~(1 << i)) & 32'h0000_000F);
      rchk(12'h000, 32'(1 << i), "raw_keep");
      wr(12'h008, 32'(1 << i));
      rchk(12'h000, 32'h0000_0000, "raw_clr");
      ichk(1'b0);
      wr(12'h004, 32'h0000_000F);
    end
    // a frozen clock enable must swallow the write
    cen <= 1'b0;
    wr(12'h004, 32'h0000_0000);
    cen <= 1'b1;
    rchk(12'h004, 32'h0000_000F, "cen_hold");
    // clear access lands in the very cycle the event is detected
    @(posedge mclk);
    req <= 4'h1;
    go  <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (7) @(posedge mclk);
    wr(12'h008, 32'h0000_0001);
    rchk(12'h000, 32'h0000_0001, "set_wins");
    while (busy === 1'b1) @(posedge mclk);
    wr(12'h004, 32'h0000_000E);
    ichk(1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rchk(12'h004, 32'h0000_000F, "mask_rst2");
    rchk(12'h000, 32'h0000_0000, "raw_rst2");
    ichk(1'b0);
    report_and_stop();
  end

  // the whole sequence needs well under 1000 cycles
  initial begin
    #(40 * 5000);
    num_errors++;
    report_and_stop();
  end
endmodule
